// ==== hw/sdram_cfg_pkg.sv ====
// constants and types shared by the sdram configuration ends
package sdram_cfg_pkg;
    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int CFG_W        = 15;
    localparam int COL_W        = 9;
    localparam int LEN_LSB      = 0;
    localparam int ORDER_BIT    = 3;
    localparam int LAT_LSB      = 4;
    localparam int OPMODE_LSB   = 7;
    localparam int WBURST_BIT   = 9;
    localparam int PARTIAL_ARRAY_REFRESH_LSB     = 0;
    localparam int TEMP_COMP_REFRESH_BITS_LSB     = 3;
    localparam int DRIVE_LSB    = 5;
    localparam logic [1:0] SEL_BASE = 2'h0;
    localparam logic [1:0] SEL_EXT  = 2'h2;
    localparam logic [2:0] LEN_1    = 3'h0;
    localparam logic [2:0] LEN_2    = 3'h1;
    localparam logic [2:0] LEN_4    = 3'h2;
    localparam logic [2:0] LEN_8    = 3'h3;
    localparam logic [2:0] LEN_PAGE = 3'h7;
    localparam logic [2:0] LAT_2    = 3'h2;
    localparam logic [2:0] LAT_3    = 3'h3;
    // ----------------------------------------------------------------
    // timing, reset values and commands
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 50;
    localparam int CFG_LOAD_WAIT_CK  = 2;
    localparam logic [CFG_W-1:0] BASE_RESET = 15'h0020;
    localparam logic [CFG_W-1:0] EXT_RESET  = 15'h0000;
    typedef enum logic [2:0] {
        CMD_NOP, CMD_LOAD, CMD_READ, CMD_WRITE, CMD_TERM
    } cmd_t;
endpackage : sdram_cfg_pkg

// ==== hw/sdram_cfg_if.sv ====
// link between controller end and memory end
`timescale 1ns/1ps
interface sdram_cfg_if;
    import sdram_cfg_pkg::*;
    cmd_t                cmd;
    logic [1:0]          bank_sel;
    logic [CFG_W-1:0]    addr;
    logic                dq_oe;
    logic [COL_W-1:0]    dq_col;
    logic                dq_valid;
    modport mem (input cmd, bank_sel, addr, output dq_oe, dq_col, dq_valid);
    modport ctl (output cmd, bank_sel, addr, input dq_oe, dq_col, dq_valid);
endinterface : sdram_cfg_if

// ==== hw/sdram_mode_config.sv ====
// memory end: configuration registers and burst sequencing
`timescale 1ns/1ps
module sdram_mode_config (
    input  wire logic                          clk,
    input  wire logic                          resetn,
    sdram_cfg_if.mem                           link,
    input  wire logic                          deep_pd,
    input  wire logic [1:0]                    sensor_rate,
    output logic [sdram_cfg_pkg::CFG_W-1:0]    base_config,
    output logic [sdram_cfg_pkg::CFG_W-1:0]    extended_config,
    output logic [3:0]                         refresh_bank_mask,
    output logic [1:0]                         refresh_row_top_zero,
    output logic [1:0]                         drive_strength,
    output logic [1:0]                         refresh_osc_rate,
    output logic                               write_active,
    output logic [sdram_cfg_pkg::COL_W-1:0]    write_col
);
    import sdram_cfg_pkg::*;

    typedef enum logic [1:0] {IDLE, RD, WR} phase_t;
    typedef struct packed {
        logic [CFG_W-1:0] base;
        logic [CFG_W-1:0] ext;
        phase_t           phase;
        logic [COL_W-1:0] start;
        logic [COL_W-1:0] beat;
        logic [COL_W-1:0] len;
        logic [2:0]       lat_cnt;
        logic             dq_oe;
        logic             dq_valid;
        logic [COL_W-1:0] dq_col;
        logic [3:0]       bmask;
        logic [1:0]       rowz;
        logic [1:0]       drive;
        logic [1:0]       osc;
        logic             wact;
        logic [COL_W-1:0] wcol;
        logic [1:0]       rate_m;
        logic [1:0]       rate_s;
    } state_t;
    state_t s, next_s;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [COL_W-1:0] blen(input logic [2:0] code);
        unique case (code)
            LEN_2:    blen = 9'h002;
            LEN_4:    blen = 9'h004;
            LEN_8:    blen = 9'h008;
            LEN_PAGE: blen = 9'h000;
            default:  blen = 9'h001;
        endcase
    endfunction : blen

    function automatic logic [COL_W-1:0] col_of(input logic [COL_W-1:0] st,
                                                input logic [COL_W-1:0] bt,
                                                input logic [COL_W-1:0] ln,
                                                input logic             il);
        logic [COL_W-1:0] m;
        m = ln - 9'h001;
        if (ln == 9'h000)
            col_of = st + bt;
        else if (il)
            col_of = (st & ~m) | ((st ^ bt) & m);
        else
            col_of = (st & ~m) | ((st + bt) & m);
    endfunction : col_of

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [COL_W-1:0] ln;
        logic             il;
        logic [2:0]       lat;
        next_s = s;
        ln  = blen(s.base[LEN_LSB +: 3]);
        il  = s.base[ORDER_BIT] && (ln != 9'h000);
        lat = (s.base[LAT_LSB +: 3] == LAT_3) ? 3'h3 : 3'h2;
        next_s.dq_valid = 1'b0;
        next_s.wact     = 1'b0;
        unique case (link.cmd)
            CMD_LOAD: begin
                if (link.bank_sel == SEL_BASE)
                    next_s.base = link.addr;
                else if (link.bank_sel == SEL_EXT)
                    next_s.ext = link.addr;
                next_s.phase = IDLE;
                next_s.dq_oe = 1'b0;
            end
            CMD_READ: begin
                next_s.phase   = RD;
                next_s.start   = link.addr[COL_W-1:0];
                next_s.beat    = 9'h000;
                next_s.len     = ln;
                next_s.lat_cnt = lat - 3'h1;
                next_s.dq_oe   = 1'b0;
            end
            CMD_WRITE: begin
                next_s.phase = WR;
                next_s.start = link.addr[COL_W-1:0];
                next_s.beat  = 9'h000;
                next_s.len   = s.base[WBURST_BIT] ? 9'h001 : ln;
                next_s.dq_oe = 1'b0;
            end
            CMD_TERM: begin
                next_s.phase = IDLE;
                next_s.dq_oe = 1'b0;
            end
            default: begin
                unique case (s.phase)
                    IDLE: next_s.dq_oe = 1'b0;
                    RD: begin
                        if (s.lat_cnt > 3'h1) begin
                            next_s.lat_cnt = s.lat_cnt - 3'h1;
                        end else if (s.lat_cnt == 3'h1) begin
                            next_s.lat_cnt = 3'h0;
                            next_s.dq_oe   = 1'b1;
                        end else begin
                            next_s.dq_valid = 1'b1;
                            next_s.dq_col   = col_of(s.start, s.beat, s.len, il);
                            next_s.beat     = s.beat + 9'h001;
                            if (s.len != 9'h000 && s.beat + 9'h001 == s.len)
                                next_s.phase = IDLE;
                        end
                    end
                    WR: begin
                        next_s.wact = 1'b1;
                        next_s.wcol = col_of(s.start, s.beat, s.len, il);
                        next_s.beat = s.beat + 9'h001;
                        if (s.len != 9'h000 && s.beat + 9'h001 == s.len)
                            next_s.phase = IDLE;
                    end
                    default: next_s.phase = IDLE;
                endcase
            end
        endcase
        if (s.phase == IDLE && !(link.cmd inside {CMD_READ, CMD_WRITE}))
            next_s.dq_oe = 1'b0;
        // deep power-down leaves ext untouched
        if (deep_pd)
            next_s.ext = next_s.ext;
        // ------------------------------------------------------------
        // self-refresh region, drive and oscillator rate
        // ------------------------------------------------------------
        unique case (s.ext[PARTIAL_ARRAY_REFRESH_LSB +: 3])
            3'h1: begin
                next_s.bmask = 4'h3;
                next_s.rowz  = 2'h0;
            end
            3'h2: begin
                next_s.bmask = 4'h1;
                next_s.rowz  = 2'h0;
            end
            3'h5: begin
                next_s.bmask = 4'h1;
                next_s.rowz  = 2'h1;
            end
            3'h6: begin
                next_s.bmask = 4'h1;
                next_s.rowz  = 2'h2;
            end
            default: begin
                next_s.bmask = 4'hf;
                next_s.rowz  = 2'h0;
            end
        endcase
        next_s.drive  = s.ext[DRIVE_LSB +: 2];
        next_s.rate_m = sensor_rate;
        next_s.rate_s = s.rate_m;
        next_s.osc    = s.rate_s;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s       <= '0;
            s.base  <= BASE_RESET;
            s.ext   <= EXT_RESET;
            s.phase <= IDLE;
            s.bmask <= 4'hf;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // link outputs
    // ----------------------------------------------------------------
    assign link.dq_oe       = s.dq_oe;
    assign link.dq_valid    = s.dq_valid;
    assign link.dq_col      = s.dq_col;

    // ----------------------------------------------------------------
    // port outputs
    // ----------------------------------------------------------------
    assign base_config      = s.base;
    assign extended_config  = s.ext;
    assign refresh_bank_mask    = s.bmask;
    assign refresh_row_top_zero = s.rowz;
    assign drive_strength   = s.drive;
    assign refresh_osc_rate = s.osc;
    assign write_active     = s.wact;
    assign write_col        = s.wcol;
endmodule : sdram_mode_config

// ==== hw/sdram_cfg_ctl.sv ====
// controller end: axi4-lite registers issue commands over the link
`timescale 1ns/1ps
module sdram_cfg_ctl (
    input  wire logic        clk,
    input  wire logic        resetn,
    sdram_cfg_if.ctl         link,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import sdram_cfg_pkg::*;
    // 0x0 command: [2:0] cmd, [4:3] bank select, [30:16] address; 0x4 status
    localparam logic [3:0] CMD_OFS  = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    typedef struct packed {
        logic             aw_got, w_got;
        logic [3:0]       awaddr;
        logic [31:0]      wdata;
        logic             bvalid, rvalid;
        logic [1:0]       bresp, rresp;
        logic [31:0]      rdata;
        cmd_t             cmd;
        logic [1:0]       sel;
        logic [CFG_W-1:0] addr;
        logic [1:0]       wait_cnt;
        logic             loaded;
    } state_t;
    state_t s, next_s;
    always_comb begin
        next_s     = s;
        next_s.cmd = CMD_NOP;
        if (s.wait_cnt != 2'h0)
            next_s.wait_cnt = s.wait_cnt - 2'h1;
        if (s_axi_awvalid && !s.aw_got) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s.w_got) begin
            next_s.w_got = 1'b1;
            next_s.wdata = s_axi_wdata;
        end
        if (s.aw_got && s.w_got && !s.bvalid && s.wait_cnt == 2'h0) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = 2'h0;
            if (s.awaddr == CMD_OFS && s.wdata[2:0] <= 3'(CMD_TERM)) begin
                next_s.cmd  = cmd_t'(s.wdata[2:0]);
                next_s.sel  = s.wdata[4:3];
                next_s.addr = s.wdata[16 +: CFG_W];
                if (s.wdata[2:0] == 3'(CMD_LOAD)) begin
                    // upper bits zeroed for both registers
                    next_s.addr[CFG_W-1:10] = '0;
                    next_s.addr[OPMODE_LSB +: 2] = 2'h0;
                    if (s.wdata[4:3] == SEL_EXT)
                        next_s.addr[CFG_W-1:7] = '0;
                    else if (s.wdata[4:3] == SEL_BASE)
                        next_s.loaded = 1'b1;
                    next_s.wait_cnt = 2'(CFG_LOAD_WAIT_CK);
                end else if (!s.loaded && s.wdata[2:0] != 3'(CMD_NOP)) begin
                    next_s.cmd   = CMD_NOP;
                    next_s.bresp = 2'h2;
                end
            end else begin
                next_s.bresp = 2'h2;
            end
        end
        if (s.bvalid && s_axi_bready)
            next_s.bvalid = 1'b0;
        if (s_axi_arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = (s_axi_araddr == STAT_OFS) ? 2'h0 : 2'h2;
            next_s.rdata  = (s_axi_araddr == STAT_OFS)
                ? {24'h0, link.dq_valid, link.dq_oe, s.loaded, s.wait_cnt != 2'h0,
                   s.aw_got, s.w_got, s.bvalid, 1'b0} : 32'h0;
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s     <= '0;
            s.cmd <= CMD_NOP;
        end else begin
            s <= next_s;
        end
    end
    assign s_axi_awready = s_axi_awvalid && !s.aw_got;
    assign s_axi_wready  = s_axi_wvalid && !s.w_got;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = s_axi_arvalid && !s.rvalid;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rresp   = s.rresp;
    assign s_axi_rdata   = s.rdata;
    assign link.cmd      = s.cmd;
    assign link.bank_sel = s.sel;
    assign link.addr     = s.addr;
endmodule : sdram_cfg_ctl

// ==== dv/sdram_cfg_assertions.sv ====
// checker of the link between controller end and memory end
`timescale 1ns/1ps
module sdram_cfg_assertions (
    input wire logic                            clk,
    input wire logic                            resetn,
    input wire sdram_cfg_pkg::cmd_t             cmd,
    input wire logic [1:0]                      bank_sel,
    input wire logic [sdram_cfg_pkg::CFG_W-1:0] addr,
    input wire logic                            dq_oe,
    input wire logic [sdram_cfg_pkg::COL_W-1:0] dq_col,
    input wire logic                            dq_valid
);
    import sdram_cfg_pkg::*;
    logic [CFG_W-1:0] cfg;
    logic [COL_W-1:0] prev_col;
    logic             prev_valid;
    logic             loaded;
    logic [2:0]       len;
    logic             seq;
    logic [COL_W-1:0] col_in;
    assign len    = cfg[LEN_LSB+:3];
    assign seq    = !cfg[ORDER_BIT];
    assign col_in = addr[COL_W-1:0];
    // ------------------------------------------------------------
    // mirror of the base configuration loaded over the link
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        prev_col   <= dq_col;
        prev_valid <= dq_valid;
        if (!resetn) begin
            cfg    <= BASE_RESET;
            loaded <= 1'b0;
        end else if (cmd == CMD_LOAD && bank_sel == SEL_BASE) begin
            cfg    <= addr;
            loaded <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    lat2_timing_a : assert property (
        !dq_oe && cmd == CMD_READ && cfg[LAT_LSB+:3] == LAT_2 |=> !dq_oe ##1 dq_oe
        ##1 dq_valid && dq_col == $past(col_in, 3)) else $error("latency two beat misplaced");
    lat3_timing_a : assert property (
        !dq_oe && cmd == CMD_READ && cfg[LAT_LSB+:3] == LAT_3 |=> !dq_oe [*2] ##1 dq_oe
        ##1 dq_valid && dq_col == $past(col_in, 4)) else $error("latency three beat misplaced");
    seq_step_a : assert property (
        dq_valid && prev_valid && seq && len == LEN_8
        |-> dq_col == {prev_col[8:3], prev_col[2:0] + 3'h1}) else $error("sequential step wrong");
    ilv_block_a : assert property (
        dq_valid && prev_valid && !seq && len == LEN_4
        |-> dq_col[8:2] == prev_col[8:2] && dq_col[1:0] != prev_col[1:0])
        else $error("beat left its block");
    page_wrap_a : assert property (
        dq_valid && prev_valid && len == LEN_PAGE |-> dq_col == prev_col + 9'h1)
        else $error("page beat not next column");
    load_wait_a : assert property (
        cmd == CMD_LOAD |=> cmd == CMD_NOP [*2]) else $error("command inside load wait");
    base_zero_a : assert property (
        cmd == CMD_LOAD && bank_sel == SEL_BASE |-> addr[14:10] == 5'h0 && addr[8:7] == 2'h0)
        else $error("base load with reserved bits set");
    ext_zero_a : assert property (
        cmd == CMD_LOAD && bank_sel == SEL_EXT |-> addr[14:7] == 8'h0)
        else $error("extended load with high bits set");
    pre_load_a : assert property (
        cmd inside {CMD_READ, CMD_WRITE, CMD_TERM} |-> loaded) else $error("access before load");
endmodule : sdram_cfg_assertions

// ==== dv/tb_top.sv ====
// self-checking bench joining controller end and memory end
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    import sdram_cfg_pkg::*;
    typedef struct {
        logic [2:0] len; logic ord; logic [2:0] lat; logic wb; logic [8:0] col; int n;
    } row_t;
    row_t rows [7] = '{'{LEN_1, 1'b0, LAT_2, 1'b0, 9'h033, 1}, '{LEN_2, 1'b0, LAT_3, 1'b1, 9'h0a1, 2},
        '{LEN_4, 1'b0, LAT_2, 1'b0, 9'h127, 4}, '{LEN_8, 1'b0, LAT_3, 1'b1, 9'h1fd, 8},
        '{LEN_2, 1'b1, LAT_2, 1'b1, 9'h055, 2}, '{LEN_4, 1'b1, LAT_3, 1'b0, 9'h0e5, 4},
        '{LEN_8, 1'b1, LAT_2, 1'b0, 9'h16b, 8}};
    logic [2:0]  partial_array_refresh_codes [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    logic [3:0]  partial_array_refresh_masks [5] = '{4'hf, 4'h3, 4'h1, 4'h1, 4'h1};
    logic [1:0]  partial_array_refresh_rows [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
    logic        clk = 1'b0, resetn = 1'b0, deep_pd = 1'b0;
    logic [1:0]  sensor_rate = 2'h0, resp, s_axi_bresp, s_axi_rresp, drive_strength;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [CFG_W-1:0] base_config, extended_config;
    logic [3:0]  refresh_bank_mask;
    logic [1:0]  refresh_osc_rate, refresh_row_top_zero;
    logic        write_active;
    logic [8:0]  write_col;
    logic [8:0]  beats [$], wcols [$];
    int          cyc, n_fail, cmp_count;
    always #25 clk = ~clk;
    sdram_cfg_if link_if ();
    sdram_cfg_ctl sdram_cfg_ctl_inst (.clk, .resetn, .link(link_if), .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    sdram_mode_config sdram_mode_config_inst (.clk, .resetn, .link(link_if), .deep_pd,
        .sensor_rate, .base_config, .extended_config, .refresh_bank_mask,
        .refresh_row_top_zero, .drive_strength, .refresh_osc_rate, .write_active, .write_col);
    sdram_cfg_assertions sdram_cfg_assertions_inst (.clk, .resetn, .cmd(link_if.cmd),
        .bank_sel(link_if.bank_sel), .addr(link_if.addr), .dq_oe(link_if.dq_oe),
        .dq_col(link_if.dq_col), .dq_valid(link_if.dq_valid));
    // ------------------------------------------------------------
    // bus tasks and monitors
    // ------------------------------------------------------------
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        forever begin
            @(negedge clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
        @(negedge clk);
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        logic ar, rv;
        @(posedge clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        forever begin
            @(negedge clk);
            ar = s_axi_arvalid && s_axi_arready;
            rv = s_axi_rvalid;
            {d, resp} = {s_axi_rdata, s_axi_rresp};
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (rv) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask : axi_rd
    task automatic cmd_wr(input cmd_t c, input logic [1:0] b, input logic [14:0] v);
        axi_wr(4'h0, {1'b0, v, 11'h0, b, 3'(c)});
    endtask : cmd_wr
    task automatic do_reset;
        @(posedge clk) resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
    endtask : do_reset
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    always @(negedge clk) begin
        if (link_if.dq_valid === 1'b1) beats.push_back(link_if.dq_col);
        if (write_active === 1'b1) wcols.push_back(write_col);
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        row_t        r;
        logic [14:0] v, e;
        logic [31:0] d;
        logic [8:0]  m, c;
        int          s;
        do_reset();
        `CHK("base rst", BASE_RESET, base_config)
        cmd_wr(CMD_READ, 2'h0, 15'h0);
        `CHK("early read", 2'h2, resp)
        $display("reset test done");
        foreach (rows[i]) begin
            r = rows[i];
            v = {5'h0, r.wb, 2'h0, r.lat, r.ord, r.len};
            cmd_wr(CMD_LOAD, SEL_BASE, v | 15'h7d80);
            `CHK("base", v, base_config)
            beats.delete();
            cmd_wr(CMD_READ, 2'h0, {6'h0, r.col});
            settle(12);
            `CHK("beats", r.n, beats.size())
            m = 9'(r.n - 1);
            foreach (beats[j]) begin
                c = r.ord ? r.col ^ 9'(j) : r.col + 9'(j);
                `CHK("col", (r.col & ~m) | (c & m), beats[j])
            end
            wcols.delete();
            cmd_wr(CMD_WRITE, 2'h0, {6'h0, r.col});
            settle(12);
            `CHK("writes", r.wb ? 1 : r.n, wcols.size())
            foreach (wcols[j]) begin
                c = r.ord ? r.col ^ 9'(j) : r.col + 9'(j);
                `CHK("wcol", (r.col & ~m) | (c & m), wcols[j])
            end
        end
        $display("burst table done");
        foreach (partial_array_refresh_codes[i]) begin
            e = {8'h0, 2'(i), 2'h3, partial_array_refresh_codes[i]};
            cmd_wr(CMD_LOAD, SEL_EXT, e | 15'h7f80);
            @(posedge clk) sensor_rate <= 2'(i);
            settle(5);
            `CHK("ext", e, extended_config)
            `CHK("mask", partial_array_refresh_masks[i], refresh_bank_mask)
            `CHK("rows", partial_array_refresh_rows[i], refresh_row_top_zero)
            `CHK("drive", 2'(i), drive_strength)
            `CHK("osc", 2'(i), refresh_osc_rate)
            `CHK("base kept", v, base_config)
        end
        beats.delete();
        cmd_wr(CMD_READ, 2'h3, 15'h0);
        settle(12);
        `CHK("any bank", 8, beats.size())
        @(posedge clk) deep_pd <= 1'b1;
        repeat (5) @(posedge clk);
        deep_pd <= 1'b0;
        settle(2);
        `CHK("ext kept", e, extended_config)
        $display("extended test done");
        v = {8'h0, LAT_2, 1'b0, LEN_PAGE};
        cmd_wr(CMD_LOAD, SEL_BASE, v);
        beats.delete();
        cmd_wr(CMD_READ, 2'h0, 15'h1fe);
        settle(6);
        cmd_wr(CMD_TERM, 2'h0, 15'h0);
        settle(6);
        s = beats.size();
        settle(8);
        `CHK("stopped", s, beats.size())
        `CHK("wrap", 9'h0, beats[2])
        $display("page test done");
        axi_wr(4'h8, 32'h1);
        `CHK("unmapped", 2'h2, resp)
        axi_wr(4'h0, 32'h5);
        `CHK("bad code", 2'h2, resp)
        `CHK("base same", v, base_config)
        axi_rd(4'h4, d);
        `CHK("loaded", 1'b1, d[5])
        axi_rd(4'hc, d);
        `CHK("bad read", 34'h2, {d, resp})
        do_reset();
        `CHK("base rst", BASE_RESET, base_config)
        `CHK("ext rst", EXT_RESET, extended_config)
        $display("refusal and reset test done");
        report_and_stop();
    end
endmodule : tb_top
